//--- dmawr_if.sv
`timescale 1ns/1ps
interface dmawr_if;
   import dmawr_pkg::*;
   logic [SB_W-1:0]   dma_wr_addr_sideband;
   logic [63:0]       dma_wr_addr;
   logic [TAG_W-1:0]  dma_wr_addr_tag;
   logic [LEN_W-1:0]  dma_wr_burst_len;
   logic              dma_wr_addr_valid;
   logic              dma_wr_addr_ready;
   logic [TAG_W-1:0]  dma_wr_data_tag;
   logic [DATA_W-1:0] dma_wr_payload;
   logic [STRB_W-1:0] dma_wr_byte_strobes;
   logic              dma_wr_final_beat;
   logic              dma_wr_payload_valid;
   logic              dma_wr_payload_ready;
   logic [TAG_W-1:0]  dma_wr_resp_tag;
   logic [RESP_W-1:0] dma_wr_resp_status;
   logic              dma_wr_resp_valid;
   logic              dma_wr_resp_ready;
   modport mgr (
      output dma_wr_addr_sideband, dma_wr_addr, dma_wr_addr_tag,
      output dma_wr_burst_len, dma_wr_addr_valid,
      input  dma_wr_addr_ready,
      output dma_wr_data_tag, dma_wr_payload, dma_wr_byte_strobes,
      output dma_wr_final_beat, dma_wr_payload_valid,
      input  dma_wr_payload_ready,
      input  dma_wr_resp_tag, dma_wr_resp_status, dma_wr_resp_valid,
      output dma_wr_resp_ready
   );
   modport sub (
      input  dma_wr_addr_sideband, dma_wr_addr, dma_wr_addr_tag,
      input  dma_wr_burst_len, dma_wr_addr_valid,
      output dma_wr_addr_ready,
      input  dma_wr_data_tag, dma_wr_payload, dma_wr_byte_strobes,
      input  dma_wr_final_beat, dma_wr_payload_valid,
      output dma_wr_payload_ready,
      output dma_wr_resp_tag, dma_wr_resp_status, dma_wr_resp_valid,
      input  dma_wr_resp_ready
   );
endinterface

//--- dmawr_mgr.sv
`timescale 1ns/1ps
module dmawr_mgr
   import dmawr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   dmawr_if.mgr                   bus,
   // User command: one pulse, taken when cmd_ready high
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire logic [63:0]       cmd_addr,
   input  wire logic [TAG_W-1:0]  cmd_tag,
   input  wire logic [LEN_W-1:0]  cmd_len,
   input  wire logic [REQID_W-1:0] cmd_req_id,
   input  wire logic [FUNC_W-1:0] cmd_func,
   input  wire logic              cmd_eop,
   input  wire logic [BCNT_W-1:0] cmd_byte_cnt,
   input  wire logic [SRC_W-1:0]  cmd_source,
   input  wire logic              cmd_axi3,
   // Beat source: beat_ready is the pop strobe
   input  wire logic              beat_valid,
   output logic                   beat_ready,
   input  wire logic [DATA_W-1:0] beat_data,
   input  wire logic [STRB_W-1:0] beat_strb,
   // Completion report
   output logic                   done_valid,
   output logic [TAG_W-1:0]       done_tag,
   output logic [RESP_W-1:0]      done_status
);
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_RESP} dmawr_st_e;
   dmawr_st_e         state_reg;
   logic [LEN_W-1:0]  beats_left_reg;
   logic              holding_reg;
   logic [SB_W-1:0]   sb_reg;
   logic [SB_W-1:0]   sb_next;
   logic [63:0]       addr_reg;
   logic [TAG_W-1:0]  tag_reg;
   logic [TAG_W-1:0]  data_tag_reg;
   logic [LEN_W-1:0]  len_reg;
   logic [DATA_W-1:0] data_reg;
   logic [STRB_W-1:0] strb_reg;
   logic              last_reg;
   logic              cmd_take;
   logic              beat_take;
   logic              beat_done;
   logic              resp_done;
   logic              eop_bit;

   assign cmd_ready  = (state_reg == ST_IDLE);
   assign cmd_take   = cmd_valid && cmd_ready;
   assign beat_done  = holding_reg && bus.dma_wr_payload_ready;
   assign resp_done  = (state_reg == ST_RESP) && bus.dma_wr_resp_valid;
   // Refill the holding stage only when empty or being drained
   assign beat_take  = (state_reg == ST_DATA) && beat_valid &&
                       (!holding_reg || beat_done) &&
                       !(holding_reg && last_reg);
   assign beat_ready = beat_take;

   // Non-DMA sources always flag end of packet
   always_comb begin
      if (cmd_source[SRC_DMA_BIT]) begin
         eop_bit = cmd_eop;
      end else begin
         eop_bit = 1'b1;
      end
   end

   // Fields placed by position so the layout lives in the package
   always_comb begin
      sb_next                       = '0;
      sb_next[SB_REQID_LO+:REQID_W] = cmd_req_id;
      sb_next[SB_FUNC_LO+:FUNC_W]   = cmd_func;
      sb_next[SB_EOP]               = eop_bit;
      sb_next[SB_RSVD]              = 1'b0;
      sb_next[SB_BCNT_LO+:BCNT_W]   = cmd_byte_cnt;
      sb_next[SRC_W-1:0]            = cmd_source;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cmd_take) begin
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (bus.dma_wr_addr_ready) begin
                  state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (beat_done && last_reg) begin
                  state_reg <= ST_RESP;
               end
            end
            ST_RESP: begin
               if (resp_done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Address-channel fields: loaded once, held until the next command
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sb_reg   <= '0;
         addr_reg <= '0;
      end else if (cmd_take) begin
         sb_reg   <= sb_next;
         addr_reg <= cmd_addr;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tag_reg      <= '0;
         data_tag_reg <= '0;
      end else if (cmd_take) begin
         tag_reg <= cmd_tag;
         // Under AXI4 the data tag means nothing; keep it at zero
         if (cmd_axi3) begin
            data_tag_reg <= cmd_tag;
         end else begin
            data_tag_reg <= '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         len_reg <= '0;
      end else if (cmd_take) begin
         len_reg <= cmd_len;
      end
   end

   // Counts down to zero; the beat taken at zero is the last
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         beats_left_reg <= '0;
      end else if (cmd_take) begin
         beats_left_reg <= cmd_len;
      end else if (beat_take && beats_left_reg != '0) begin
         beats_left_reg <= beats_left_reg - 4'h1;
      end
   end

   // Holding stage: stays put while valid and not ready
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         holding_reg <= 1'b0;
      end else if (beat_take) begin
         holding_reg <= 1'b1;
      end else if (beat_done) begin
         holding_reg <= 1'b0;
      end
   end

   // Loaded only on a take, so a stalled beat never moves
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         data_reg <= '0;
         strb_reg <= '0;
      end else if (beat_take) begin
         data_reg <= beat_data;
         strb_reg <= beat_strb;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         last_reg <= 1'b0;
      end else if (beat_take) begin
         last_reg <= (beats_left_reg == '0);
      end else if (beat_done) begin
         last_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         done_valid <= 1'b0;
      end else begin
         done_valid <= resp_done;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         done_tag    <= '0;
         done_status <= RESP_OKAY;
      end else if (resp_done) begin
         done_tag    <= bus.dma_wr_resp_tag;
         done_status <= bus.dma_wr_resp_status;
      end
   end

   assign bus.dma_wr_addr_sideband = sb_reg;
   assign bus.dma_wr_addr          = addr_reg;
   assign bus.dma_wr_addr_tag      = tag_reg;
   assign bus.dma_wr_burst_len     = len_reg;
   assign bus.dma_wr_addr_valid    = (state_reg == ST_ADDR);
   assign bus.dma_wr_data_tag      = data_tag_reg;
   assign bus.dma_wr_payload       = data_reg;
   assign bus.dma_wr_byte_strobes  = strb_reg;
   // last_reg is only ever set beside holding_reg
   assign bus.dma_wr_final_beat    = last_reg;
   assign bus.dma_wr_payload_valid = holding_reg;
   assign bus.dma_wr_resp_ready    = (state_reg == ST_RESP);
endmodule

//--- dmawr_monitor.sv
`timescale 1ns/1ps
module dmawr_monitor
   import dmawr_pkg::*;
(
   input wire logic              mclk,
   input wire logic              sys_rst,
   input wire logic [SB_W-1:0]   dma_wr_addr_sideband,
   input wire logic [TAG_W-1:0]  dma_wr_addr_tag,
   input wire logic [LEN_W-1:0]  dma_wr_burst_len,
   input wire logic              dma_wr_addr_valid,
   input wire logic              dma_wr_addr_ready,
   input wire logic [DATA_W-1:0] dma_wr_payload,
   input wire logic              dma_wr_final_beat,
   input wire logic              dma_wr_payload_valid,
   input wire logic              dma_wr_payload_ready,
   input wire logic [TAG_W-1:0]  dma_wr_resp_tag,
   input wire logic              dma_wr_resp_valid,
   input wire logic              dma_wr_resp_ready
);
   logic             busy_reg;
   logic [LEN_W-1:0] beat_reg;
   logic [LEN_W-1:0] len_reg;
   logic [TAG_W-1:0] tag_reg;
   wire aw_hs = dma_wr_addr_valid && dma_wr_addr_ready;
   wire w_hs  = dma_wr_payload_valid && dma_wr_payload_ready;
   // Busy spans address acceptance to last data beat
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         busy_reg <= 1'b0;
         beat_reg <= '0;
      end else if (aw_hs) begin
         busy_reg <= 1'b1;
         beat_reg <= '0;
      end else if (w_hs) begin
         busy_reg <= !dma_wr_final_beat;
         beat_reg <= beat_reg + 4'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (aw_hs) begin
         len_reg <= dma_wr_burst_len;
         tag_reg <= dma_wr_addr_tag;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_rsvd_zero: assert property (
      dma_wr_addr_valid |-> !dma_wr_addr_sideband[SB_RSVD])
      else $error("reserved sideband bit set");
   a_eop_nondma: assert property (
      dma_wr_addr_valid && !dma_wr_addr_sideband[SRC_DMA_BIT]
      |-> dma_wr_addr_sideband[SB_EOP]) else $error("eop low, non-dma");
   a_addr_held: assert property (
      dma_wr_addr_valid && !dma_wr_addr_ready |=> dma_wr_addr_valid
      && $stable(dma_wr_addr_sideband)) else $error("address dropped");
   a_data_held: assert property (
      dma_wr_payload_valid && !dma_wr_payload_ready |=> dma_wr_payload_valid
      && $stable(dma_wr_payload) && $stable(dma_wr_final_beat))
      else $error("data beat changed while stalled");
   a_last_beat: assert property (
      w_hs |-> dma_wr_final_beat == (beat_reg == len_reg))
      else $error("final beat misplaced");
   a_data_in_burst: assert property (
      dma_wr_payload_valid |-> busy_reg) else $error("data outside burst");
   a_resp_accept: assert property (
      w_hs && dma_wr_final_beat |-> ##[0:2] dma_wr_resp_ready)
      else $error("response not accepted");
   a_resp_held: assert property (
      dma_wr_resp_valid && !dma_wr_resp_ready |=> dma_wr_resp_valid
      && $stable(dma_wr_resp_tag)) else $error("response dropped");
   a_resp_taken: assert property (
      dma_wr_resp_valid |-> dma_wr_resp_ready)
      else $error("response left waiting");
   a_resp_tag: assert property (
      dma_wr_resp_valid |-> dma_wr_resp_tag == tag_reg)
      else $error("response tag mismatch");
   cover property (dma_wr_payload_valid && !dma_wr_payload_ready);
   cover property (w_hs && dma_wr_final_beat && len_reg == 4'hF);
   cover property (dma_wr_addr_valid && !dma_wr_addr_ready);
endmodule

//--- dmawr_pkg.sv
package dmawr_pkg;
   localparam int DATA_W     = 512;
   localparam int STRB_W     = 64;
   localparam int TAG_W      = 4;
   localparam int LEN_W      = 4;
   localparam int RESP_W     = 2;
   localparam int SB_W       = 48;
   localparam int REQID_W    = 16;
   localparam int FUNC_W     = 8;
   localparam int BCNT_W     = 10;
   localparam int SRC_W      = 12;
   localparam int SB_REQID_LO = 32;
   localparam int SB_FUNC_LO = 24;
   localparam int SB_EOP     = 23;
   localparam int SB_RSVD    = 22;
   localparam int SB_BCNT_LO = 12;
   localparam int SRC_DMA    = 11;
   localparam int SRC_DMA_BIT = 11;
   localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
   localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
endpackage

//--- dmawr_sub.sv
`timescale 1ns/1ps
module dmawr_sub
   import dmawr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   dmawr_if.sub                   bus,
   input  wire logic              usr_stall,
   input  wire logic              usr_error,
   output logic                   fifo_wr_en,
   output logic [DATA_W-1:0]      fifo_wr_data,
   output logic [STRB_W-1:0]      fifo_wr_strb,
   output logic [SRC_W-1:0]       fifo_wr_source,
   output logic                   fifo_wr_eop
);
   typedef enum logic [1:0] {SS_ADDR, SS_DATA, SS_RESP} dmawr_sst_e;
   dmawr_sst_e        state_reg;
   logic [TAG_W-1:0]  tag_reg;
   logic [SB_W-1:0]   sb_reg;
   logic [RESP_W-1:0] status_reg;
   logic              beat_fire;

   assign bus.dma_wr_addr_ready    = (state_reg == SS_ADDR) && !usr_stall;
   assign bus.dma_wr_payload_ready = (state_reg == SS_DATA) &&
                                     !usr_stall;
   assign beat_fire = bus.dma_wr_payload_valid && bus.dma_wr_payload_ready;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= SS_ADDR;
      end else begin
         case (state_reg)
            SS_ADDR: if (bus.dma_wr_addr_valid && bus.dma_wr_addr_ready)
               state_reg <= SS_DATA;
            SS_DATA: if (beat_fire && bus.dma_wr_final_beat)
               state_reg <= SS_RESP;
            SS_RESP: if (bus.dma_wr_resp_ready) state_reg <= SS_ADDR;
            default: state_reg <= SS_ADDR;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tag_reg    <= '0;
         sb_reg     <= '0;
         status_reg <= RESP_OKAY;
      end else if (bus.dma_wr_addr_valid && bus.dma_wr_addr_ready) begin
         tag_reg    <= bus.dma_wr_addr_tag;
         sb_reg     <= bus.dma_wr_addr_sideband;
         status_reg <= RESP_OKAY;
      end else if (beat_fire && usr_error) begin
         status_reg <= RESP_SLVERR;
      end
   end

   // FIFO write carries end-of-packet so partial words are flushed
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fifo_wr_en     <= 1'b0;
         fifo_wr_data   <= '0;
         fifo_wr_strb   <= '0;
         fifo_wr_source <= '0;
         fifo_wr_eop    <= 1'b0;
      end else begin
         fifo_wr_en <= beat_fire;
         if (beat_fire) begin
            fifo_wr_data   <= bus.dma_wr_payload;
            fifo_wr_strb   <= bus.dma_wr_byte_strobes;
            fifo_wr_source <= sb_reg[SRC_W-1:0];
            fifo_wr_eop    <= bus.dma_wr_final_beat &&
                              sb_reg[SB_EOP];
         end
      end
   end

   assign bus.dma_wr_resp_valid  = (state_reg == SS_RESP);
   assign bus.dma_wr_resp_tag    = tag_reg;
   assign bus.dma_wr_resp_status = status_reg;
endmodule

//--- tb_dma_manager_write_port.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      num_errors++; \
      $display("ERROR %s exp %0h got %0h", nm, ex, got); \
   end \
end
`define MC(s) .s(u_dmawr_if.s)
module tb_dma_manager_write_port import dmawr_pkg::*; ;
   logic mclk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, cmd_eop = 1'b0;
   logic cmd_axi3 = 1'b0, beat_valid = 1'b0, usr_stall = 1'b0;
   logic usr_error = 1'b0, cmd_ready, beat_ready, done_valid;
   logic fifo_wr_en, fifo_wr_eop, eop_x;
   logic [63:0]         cmd_addr = '0, cur_addr;
   logic [TAG_W-1:0]    cmd_tag = '0, cur_dtag, done_tag;
   logic [LEN_W-1:0]    cmd_len = '0, cur_len;
   logic [REQID_W-1:0]  cmd_req_id = '0;
   logic [FUNC_W-1:0]   cmd_func = '0;
   logic [BCNT_W-1:0]   cmd_byte_cnt = '0;
   logic [SRC_W-1:0]    cmd_source = '0, fifo_wr_source;
   logic [DATA_W-1:0]   beat_data = '0, fifo_wr_data;
   logic [STRB_W-1:0]   beat_strb = '0, fifo_wr_strb;
   logic [RESP_W-1:0]   done_status;
   logic [SB_W-1:0]     cur_sb = '0, sb_seen;
   logic [DATA_W+STRB_W+SRC_W:0] exp_beat, got_beat, beat_q[$];
   logic [TAG_W+RESP_W-1:0]      exp_done, done_q[$];
   int num_errors = 0, samples_checked = 0;
   always #25 mclk = !mclk;
   dmawr_if u_dmawr_if ();
   dmawr_mgr u_dmawr_mgr (.mclk, .sys_rst, .bus(u_dmawr_if), .cmd_valid,
      .cmd_ready, .cmd_addr, .cmd_tag, .cmd_len, .cmd_req_id, .cmd_func,
      .cmd_eop, .cmd_byte_cnt, .cmd_source, .cmd_axi3, .beat_valid,
      .beat_ready, .beat_data, .beat_strb, .done_valid, .done_tag,
      .done_status);
   dmawr_sub u_dmawr_sub (.mclk, .sys_rst, .bus(u_dmawr_if), .usr_stall,
      .usr_error, .fifo_wr_en, .fifo_wr_data, .fifo_wr_strb,
      .fifo_wr_source, .fifo_wr_eop);
   dmawr_monitor u_dmawr_monitor (.mclk, .sys_rst,
      `MC(dma_wr_addr_sideband), `MC(dma_wr_addr_tag), `MC(dma_wr_burst_len),
      `MC(dma_wr_addr_valid), `MC(dma_wr_addr_ready), `MC(dma_wr_payload),
      `MC(dma_wr_final_beat), `MC(dma_wr_payload_valid),
      `MC(dma_wr_payload_ready), `MC(dma_wr_resp_tag),
      `MC(dma_wr_resp_valid), `MC(dma_wr_resp_ready));
   // Random back-pressure on both subordinate channels
   always @(posedge mclk) usr_stall <= ($urandom % 4) == 0;
   task automatic send(input logic [3:0] len, input logic err);
      @(negedge mclk);
      while (cmd_ready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      {cmd_req_id, cmd_func, cmd_eop, cmd_byte_cnt} <=
         35'({$urandom, $urandom});
      {cmd_source, cmd_tag, cmd_axi3} <= 17'($urandom);
      cmd_addr <= {$urandom, $urandom};
      cmd_len <= len;
      usr_error <= err;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      eop_x = cmd_source[SRC_DMA_BIT] ? cmd_eop : 1'b1;
      cur_sb = {cmd_req_id, cmd_func, eop_x, 1'b0, cmd_byte_cnt, cmd_source};
      cur_len = len;
      cur_addr = cmd_addr;
      cur_dtag = cmd_axi3 ? cmd_tag : '0;
      done_q.push_back({cmd_tag, err ? RESP_SLVERR : RESP_OKAY});
      for (int i = 0; i <= len; i++) begin
         beat_data <= {16{$urandom}};
         beat_strb <= {$urandom, $urandom};
         beat_valid <= 1'b1;
         @(negedge mclk);
         while (beat_ready !== 1'b1) @(negedge mclk);
         @(posedge mclk);
         beat_q.push_back({beat_data, beat_strb, cmd_source,
                           eop_x && i == len});
      end
      beat_valid <= 1'b0;
   endtask
   always @(posedge mclk) begin
      if (!sys_rst && u_dmawr_if.dma_wr_addr_valid &&
          u_dmawr_if.dma_wr_addr_ready) begin
         sb_seen = u_dmawr_if.dma_wr_addr_sideband;
         `CHK("req id", cur_sb[47:32], sb_seen[47:32])
         `CHK("func", cur_sb[31:24], sb_seen[31:24])
         `CHK("eop", cur_sb[23], sb_seen[23])
         `CHK("reserved", 1'b0, sb_seen[22])
         `CHK("byte cnt", cur_sb[21:12], sb_seen[21:12])
         `CHK("source", cur_sb[11:0], sb_seen[11:0])
         `CHK("burst len", cur_len, u_dmawr_if.dma_wr_burst_len)
         `CHK("addr", cur_addr, u_dmawr_if.dma_wr_addr)
      end
      if (u_dmawr_if.dma_wr_payload_valid &&
          u_dmawr_if.dma_wr_payload_ready)
         `CHK("data tag", cur_dtag, u_dmawr_if.dma_wr_data_tag)
      if (fifo_wr_en === 1'b1) begin
         exp_beat = beat_q.pop_front();
         got_beat = {fifo_wr_data, fifo_wr_strb, fifo_wr_source, fifo_wr_eop};
         `CHK("beat", exp_beat, got_beat)
      end
      if (done_valid === 1'b1) begin
         exp_done = done_q.pop_front();
         `CHK("done", exp_done, {done_tag, done_status})
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #1000000;
      num_errors++;
      test_done();
   end
   initial begin
      void'($urandom(9965));
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int t = 0; t < 12; t++) begin
         send(t == 0 ? 4'h0 : (t == 1 ? 4'hF : 4'($urandom)), t % 3 == 2);
         $display("test %0d done", t);
      end
      repeat (200) begin
         @(negedge mclk);
         if (done_q.size() == 0 && beat_q.size() == 0) break;
      end
      // Results still owed after the drain window count as a mismatch
      if (done_q.size() != 0 || beat_q.size() != 0) begin
         num_errors++;
         $display("ERROR drain exp 0 got %0d", done_q.size() + beat_q.size());
      end
      test_done();
   end
endmodule
